//--- design/dlp_pkg.sv
// ****************************************************************
// Register map, reset values and timing
// ****************************************************************
package dlp_pkg;
   // Register numbers on the configuration port
   localparam logic [7:0] REG_CTRL_BLOCK_MASK = 8'h0e;
   localparam logic [7:0] REG_LOST_CARRIER = 8'h12;
   localparam logic [7:0] REG_TX_TIMEOUT = 8'h13;
   localparam logic [7:0] REG_LINE_SPEED = 8'h14;
   localparam logic [7:0] REG_GROUP_CODE = 8'h15;
   localparam logic [7:0] REG_UNIT_CODE = 8'h16;
   localparam logic [7:0] REG_HANDSHAKE = 8'h17;
   localparam logic [7:0] REG_TX_BLOCK_LIMIT = 8'h18;
   localparam logic [7:0] REG_PARITY = 8'h24;

   // Reset values
   localparam logic [7:0] RST_CTRL_BLOCK_MASK = 8'h06;
   localparam logic [7:0] RST_LOST_CARRIER = 8'h28;
   localparam logic [7:0] RST_TX_TIMEOUT = 8'h0a;
   localparam logic [7:0] RST_LINE_SPEED = 8'h0e;
   localparam logic [7:0] RST_GROUP_CODE = 8'h01;
   localparam logic [7:0] RST_UNIT_CODE = 8'h01;
   localparam logic [7:0] RST_HANDSHAKE = 8'h00;
   localparam logic [7:0] RST_TX_BLOCK_LIMIT = 8'h00;
   localparam logic [7:0] RST_PARITY = 8'h00;

   // Mask bit positions
   localparam int MASK_START_BIT = 0;
   localparam int MASK_ETX_BIT = 1;
   localparam int MASK_ETB_BIT = 2;

   // Field limits and encodings
   localparam logic [7:0] ID_CODE_MAX = 8'h1a;
   localparam logic [7:0] ID_CHAR_BASE = 8'h40;
   localparam logic [7:0] PARITY_ODD = 8'h01;
   localparam logic [7:0] SPEED_EXTERNAL = 8'h00;
   localparam logic [9:0] TX_BLOCK_MAX = 10'h200;

   // Control block codes in the inbound queue
   localparam logic [7:0] CB_BLOCK_START = 8'h01;
   localparam logic [7:0] CB_BLOCK_ETX = 8'h02;
   localparam logic [7:0] CB_BLOCK_ETB = 8'h03;

   // Timing
   localparam int CLOCK_HZ = 50000000;
   localparam int LOST_UNIT_MS = 10;
   localparam int TX_UNIT_S = 1;
   localparam int LOST_UNIT_CYCLES = CLOCK_HZ / 1000 * LOST_UNIT_MS;
   localparam int TX_UNIT_CYCLES = CLOCK_HZ * TX_UNIT_S;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_DATA = 2'b10,
      ST_END = 2'b11
   } dlp_state_type;
endpackage

//--- design/dlp_port.sv
`timescale 1ns/1ps
// How it works
// - Mask bit 1 set: control block after each received block ending in whole records.
// - Mask bit 2 set: control block after a block whose last record continues.
// - Mask bit 0 set: control block marks start of every received block.
// - One line speed serves both transmit and receive.
// - Speed code 0 uses external clock; 7 to 15 give 300 to 19200 baud.
// - Group code and unit code sit in adjacent registers as one pair.
// - Identifier codes 0 to 26; character equals code plus 64.
// - Handshake register selects hardware handshake; zero turns it off.
// - No character flow control; the remote host paces all transfers.
// - Nonzero block limit N caps each transmitted block at 2N bytes.
// - Block limit zero caps transmitted blocks at 512 bytes; zero is default.
// - Parity register: 0 means none, 1 means odd.
// - Registers 25 to 35 and 37 upward have no effect.
// - Control block mask resets to 6.
// - Group code resets to 1, the letter A.
// - Lost carrier counts 10 ms units, default 40, giving 400 ms.
// - Transmit timeout in seconds aborts a stalled transmission.
module dlp_port #(
   parameter int LOST_UNIT_CYC = dlp_pkg::LOST_UNIT_CYCLES,
   parameter int TX_UNIT_CYC = dlp_pkg::TX_UNIT_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic linkClock,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxEnd,
   input wire logic rxCont,
   output logic rxReady,
   output logic inValid,
   output logic [7:0] inData,
   output logic inCtl,
   input wire logic inReady,
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic txLast,
   output logic txReady,
   input wire logic lineReady,
   output logic lineValid,
   output logic [7:0] lineData,
   output logic lineParity,
   output logic lineBlockEnd,
   output logic txAbort,
   input wire logic carrier,
   output logic lostCarrier,
   output logic baudTick,
   output logic extClockSel,
   output logic hwHandshakeEn,
   output logic [7:0] groupChar,
   output logic [7:0] unitChar
);
   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Cycles per bit at the selected speed; zero means no internal clock
   function automatic logic [17:0] baud_div(input logic [7:0] code);
      case (code)
         8'h07: baud_div = 18'(dlp_pkg::CLOCK_HZ / 300);
         8'h08: baud_div = 18'(dlp_pkg::CLOCK_HZ / 600);
         8'h09: baud_div = 18'(dlp_pkg::CLOCK_HZ / 1200);
         8'h0a: baud_div = 18'(dlp_pkg::CLOCK_HZ / 1800);
         8'h0b: baud_div = 18'(dlp_pkg::CLOCK_HZ / 2400);
         8'h0c: baud_div = 18'(dlp_pkg::CLOCK_HZ / 3600);
         8'h0d: baud_div = 18'(dlp_pkg::CLOCK_HZ / 4800);
         8'h0e: baud_div = 18'(dlp_pkg::CLOCK_HZ / 9600);
         8'h0f: baud_div = 18'(dlp_pkg::CLOCK_HZ / 19200);
         default: baud_div = 18'h00000;
      endcase
   endfunction

   // Byte limit of one transmitted block
   function automatic logic [9:0] block_limit(input logic [7:0] n);
      block_limit = (n == 8'h00) ? dlp_pkg::TX_BLOCK_MAX : {1'b0, n, 1'b0};
   endfunction

   // ****************************************************************
   // Link domain: receive capture and toggle request
   // ****************************************************************
   typedef struct packed {
      logic rstS1;
      logic rstS2;
      logic ackS1;
      logic ackS2;
      logic req;
      logic busy;
      logic first;
      logic [7:0] data;
      logic isEnd;
      logic isCont;
      logic ready;
   } dlp_link_type;

   dlp_link_type lnk_q, lnk_d;
   logic sysAck;
   logic linkFirst_q;

   // Hold one byte until the core has emitted it and its markers
   always_comb begin
      lnk_d = lnk_q;
      lnk_d.rstS1 = rst;
      lnk_d.rstS2 = lnk_q.rstS1;
      lnk_d.ackS1 = sysAck;
      lnk_d.ackS2 = lnk_q.ackS1;
      if (lnk_q.busy && lnk_q.ackS2 == lnk_q.req) begin
         lnk_d.busy = 1'b0;
      end
      if (!lnk_q.busy && rxValid) begin
         lnk_d.data = rxData;
         lnk_d.isEnd = rxEnd;
         lnk_d.isCont = rxCont;
         lnk_d.first = linkFirst_q;
         lnk_d.req = ~lnk_q.req;
         lnk_d.busy = 1'b1;
      end
      lnk_d.ready = ~lnk_d.busy;
      if (lnk_q.rstS2) begin
         lnk_d.req = 1'b0;
         lnk_d.busy = 1'b0;
         lnk_d.ready = 1'b0;
      end
   end

   // First-of-block flag is tracked apart so it follows the accepted byte
   always_ff @(posedge linkClock) begin
      lnk_q <= lnk_d;
      if (lnk_q.rstS2) begin
         linkFirst_q <= 1'b1;
      end else if (!lnk_q.busy && rxValid) begin
         linkFirst_q <= rxEnd;
      end
   end

   assign rxReady = lnk_q.ready;

   // ****************************************************************
   // Core domain state
   // ****************************************************************
   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] lostSet;
      logic [7:0] txTimeSet;
      logic [7:0] speed;
      logic [7:0] groupCode;
      logic [7:0] unitCode;
      logic [7:0] handshake;
      logic [7:0] blockLim;
      logic [7:0] parity;
      logic [7:0] rdData;
      logic reqS1;
      logic reqS2;
      logic ack;
      dlp_pkg::dlp_state_type state;
      logic [7:0] byteHold;
      logic firstHold;
      logic endHold;
      logic contHold;
      logic inValid;
      logic [7:0] inData;
      logic inCtl;
      logic lrS1;
      logic lrS2;
      logic carS1;
      logic carS2;
      logic [9:0] txCount;
      logic txReady;
      logic lineValid;
      logic [7:0] lineData;
      logic lineParity;
      logic lineBlockEnd;
      logic txAbort;
      logic [31:0] txPre;
      logic [7:0] txSec;
      logic [31:0] lostPre;
      logic [7:0] lostUnits;
      logic lost;
      logic [17:0] baudCnt;
      logic baudTick;
      logic extSel;
      logic hwHs;
      logic [7:0] groupChar;
      logic [7:0] unitChar;
   } dlp_core_type;

   dlp_core_type c_q, c_d;
   logic [9:0] txLimit;
   logic [17:0] curDiv;
   logic txTake;

   assign txLimit = block_limit(c_q.blockLim);
   assign curDiv = baud_div(c_q.speed);
   assign txTake = txValid && c_q.txReady;

   always_comb begin
      c_d = c_q;
      // ****************************************************************
      // Register port
      // ****************************************************************
      c_d.reqS1 = lnk_q.req;
      c_d.reqS2 = c_q.reqS1;
      c_d.lrS1 = lineReady;
      c_d.lrS2 = c_q.lrS1;
      c_d.carS1 = carrier;
      c_d.carS2 = c_q.carS1;
      // Unlisted numbers are ignored and read as zero
      if (regWrite) begin
         case (regAddr)
            dlp_pkg::REG_CTRL_BLOCK_MASK: c_d.mask = regWrData;
            dlp_pkg::REG_LOST_CARRIER: c_d.lostSet = regWrData;
            dlp_pkg::REG_TX_TIMEOUT: c_d.txTimeSet = regWrData;
            dlp_pkg::REG_LINE_SPEED: c_d.speed = regWrData;
            dlp_pkg::REG_GROUP_CODE: begin
               if (regWrData <= dlp_pkg::ID_CODE_MAX) begin
                  c_d.groupCode = regWrData;
               end
            end
            dlp_pkg::REG_UNIT_CODE: begin
               if (regWrData <= dlp_pkg::ID_CODE_MAX) begin
                  c_d.unitCode = regWrData;
               end
            end
            dlp_pkg::REG_HANDSHAKE: c_d.handshake = regWrData;
            dlp_pkg::REG_TX_BLOCK_LIMIT: c_d.blockLim = regWrData;
            dlp_pkg::REG_PARITY: begin
               if (regWrData <= dlp_pkg::PARITY_ODD) begin
                  c_d.parity = regWrData;
               end
            end
            default: c_d.rdData = c_q.rdData;
         endcase
      end
      if (regRead) begin
         case (regAddr)
            dlp_pkg::REG_CTRL_BLOCK_MASK: c_d.rdData = c_q.mask;
            dlp_pkg::REG_LOST_CARRIER: c_d.rdData = c_q.lostSet;
            dlp_pkg::REG_TX_TIMEOUT: c_d.rdData = c_q.txTimeSet;
            dlp_pkg::REG_LINE_SPEED: c_d.rdData = c_q.speed;
            dlp_pkg::REG_GROUP_CODE: c_d.rdData = c_q.groupCode;
            dlp_pkg::REG_UNIT_CODE: c_d.rdData = c_q.unitCode;
            dlp_pkg::REG_HANDSHAKE: c_d.rdData = c_q.handshake;
            dlp_pkg::REG_TX_BLOCK_LIMIT: c_d.rdData = c_q.blockLim;
            dlp_pkg::REG_PARITY: c_d.rdData = c_q.parity;
            default: c_d.rdData = 8'h00;
         endcase
      end
      // Decoded settings, registered so outputs come from flops
      c_d.groupChar = c_q.groupCode + dlp_pkg::ID_CHAR_BASE;
      c_d.unitChar = c_q.unitCode + dlp_pkg::ID_CHAR_BASE;
      c_d.hwHs = (c_q.handshake != 8'h00);
      c_d.extSel = (c_q.speed == dlp_pkg::SPEED_EXTERNAL);

      // ****************************************************************
      // Inbound sequencing
      // ****************************************************************
      // One byte in flight; its ack waits for every marker, so order holds
      case (c_q.state)
         dlp_pkg::ST_IDLE: begin
            if (c_q.reqS2 != c_q.ack) begin
               c_d.byteHold = lnk_q.data;
               c_d.firstHold = lnk_q.first;
               c_d.endHold = lnk_q.isEnd;
               c_d.contHold = lnk_q.isCont;
               c_d.inValid = 1'b1;
               if (lnk_q.first && c_q.mask[dlp_pkg::MASK_START_BIT]) begin
                  c_d.state = dlp_pkg::ST_START;
                  c_d.inData = dlp_pkg::CB_BLOCK_START;
                  c_d.inCtl = 1'b1;
               end else begin
                  c_d.state = dlp_pkg::ST_DATA;
                  c_d.inData = lnk_q.data;
                  c_d.inCtl = 1'b0;
               end
            end
         end
         dlp_pkg::ST_START: begin
            if (inReady) begin
               c_d.state = dlp_pkg::ST_DATA;
               c_d.inData = c_q.byteHold;
               c_d.inCtl = 1'b0;
            end
         end
         dlp_pkg::ST_DATA: begin
            if (inReady) begin
               if (c_q.endHold && !c_q.contHold && c_q.mask[dlp_pkg::MASK_ETX_BIT]) begin
                  c_d.state = dlp_pkg::ST_END;
                  c_d.inData = dlp_pkg::CB_BLOCK_ETX;
                  c_d.inCtl = 1'b1;
               end else if (c_q.endHold && c_q.contHold
                            && c_q.mask[dlp_pkg::MASK_ETB_BIT]) begin
                  c_d.state = dlp_pkg::ST_END;
                  c_d.inData = dlp_pkg::CB_BLOCK_ETB;
                  c_d.inCtl = 1'b1;
               end else begin
                  c_d.state = dlp_pkg::ST_IDLE;
                  c_d.inValid = 1'b0;
                  c_d.ack = c_q.reqS2;
               end
            end
         end
         dlp_pkg::ST_END: begin
            if (inReady) begin
               c_d.state = dlp_pkg::ST_IDLE;
               c_d.inValid = 1'b0;
               c_d.inCtl = 1'b0;
               c_d.ack = c_q.reqS2;
            end
         end
         default: c_d.state = dlp_pkg::ST_IDLE;
      endcase

      // ****************************************************************
      // Transmit path: block limit, parity, stall timeout
      // ****************************************************************
      // Pacing comes only from the line ready pin; no XON/XOFF here
      c_d.txReady = c_q.lrS2;
      c_d.lineBlockEnd = 1'b0;
      c_d.txAbort = 1'b0;
      c_d.lineValid = txTake;
      if (txTake) begin
         c_d.lineData = txData;
         c_d.lineParity = (c_q.parity == dlp_pkg::PARITY_ODD) & ~(^txData);
         if (txLast || c_q.txCount + 10'h001 >= txLimit) begin
            c_d.lineBlockEnd = 1'b1;
            c_d.txCount = 10'h000;
         end else begin
            c_d.txCount = c_q.txCount + 10'h001;
         end
      end
      // Stall time counts only while data waits and the line refuses it
      if (txValid && !c_q.txReady && c_q.txTimeSet != 8'h00) begin
         if (c_q.txPre == 32'(TX_UNIT_CYC - 1)) begin
            c_d.txPre = 32'h00000000;
            if (c_q.txSec + 8'h01 >= c_q.txTimeSet) begin
               c_d.txSec = 8'h00;
               c_d.txAbort = 1'b1;
               c_d.txCount = 10'h000;
            end else begin
               c_d.txSec = c_q.txSec + 8'h01;
            end
         end else begin
            c_d.txPre = c_q.txPre + 32'h00000001;
         end
      end else begin
         c_d.txPre = 32'h00000000;
         c_d.txSec = 8'h00;
      end

      // ****************************************************************
      // Lost carrier and line speed
      // ****************************************************************
      if (c_q.carS2 || c_q.lostSet == 8'h00) begin
         c_d.lostPre = 32'h00000000;
         c_d.lostUnits = 8'h00;
         c_d.lost = 1'b0;
      end else if (!c_q.lost) begin
         if (c_q.lostPre == 32'(LOST_UNIT_CYC - 1)) begin
            c_d.lostPre = 32'h00000000;
            c_d.lostUnits = c_q.lostUnits + 8'h01;
            c_d.lost = (c_q.lostUnits + 8'h01 >= c_q.lostSet);
         end else begin
            c_d.lostPre = c_q.lostPre + 32'h00000001;
         end
      end
      // One divider drives both directions
      c_d.baudTick = 1'b0;
      if (curDiv == 18'h00000) begin
         c_d.baudCnt = 18'h00000;
      end else if (c_q.baudCnt + 18'h00001 >= curDiv) begin
         c_d.baudCnt = 18'h00000;
         c_d.baudTick = 1'b1;
      end else begin
         c_d.baudCnt = c_q.baudCnt + 18'h00001;
      end

      if (rst) begin
         c_d = '0;
         c_d.mask = dlp_pkg::RST_CTRL_BLOCK_MASK;
         c_d.lostSet = dlp_pkg::RST_LOST_CARRIER;
         c_d.txTimeSet = dlp_pkg::RST_TX_TIMEOUT;
         c_d.speed = dlp_pkg::RST_LINE_SPEED;
         c_d.groupCode = dlp_pkg::RST_GROUP_CODE;
         c_d.unitCode = dlp_pkg::RST_UNIT_CODE;
         c_d.handshake = dlp_pkg::RST_HANDSHAKE;
         c_d.blockLim = dlp_pkg::RST_TX_BLOCK_LIMIT;
         c_d.parity = dlp_pkg::RST_PARITY;
         c_d.state = dlp_pkg::ST_IDLE;
      end
   end

   // Single register stage for all core state
   always_ff @(posedge clock) begin
      c_q <= c_d;
   end

   assign sysAck = c_q.ack;
   assign regRdData = c_q.rdData;
   assign inValid = c_q.inValid;
   assign inData = c_q.inData;
   assign inCtl = c_q.inCtl;
   assign txReady = c_q.txReady;
   assign lineValid = c_q.lineValid;
   assign lineData = c_q.lineData;
   assign lineParity = c_q.lineParity;
   assign lineBlockEnd = c_q.lineBlockEnd;
   assign txAbort = c_q.txAbort;
   assign lostCarrier = c_q.lost;
   assign baudTick = c_q.baudTick;
   assign extClockSel = c_q.extSel;
   assign hwHandshakeEn = c_q.hwHs;
   assign groupChar = c_q.groupChar;
   assign unitChar = c_q.unitChar;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_mask_reset: assert property (@(posedge clock) rst |=> c_q.mask == 8'h06)
      else $error("mask not 6 after reset");
   a_group_reset: assert property (@(posedge clock) rst |=> c_q.groupCode == 8'h01)
      else $error("group code not 1 after reset");
   a_id_range: assert property (@(posedge clock) disable iff (rst)
      regWrite && regAddr == dlp_pkg::REG_GROUP_CODE && regWrData > 8'h1a
      |=> $stable(c_q.groupCode))
      else $error("out of range group code taken");
   a_id_char: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) |-> groupChar == $past(c_q.groupCode) + 8'h40)
      else $error("group char not code plus 64");
   a_unused_reg: assert property (@(posedge clock) disable iff (rst)
      regRead && regAddr == 8'h19 |=> regRdData == 8'h00)
      else $error("unused register read nonzero");
   a_block_limit: assert property (@(posedge clock) disable iff (rst)
      txTake && c_q.txCount + 10'h001 >= txLimit |=> lineValid && lineBlockEnd)
      else $error("block not closed at limit");
   a_zero_limit: assert property (@(posedge clock) disable iff (rst)
      c_q.blockLim == 8'h00 && lineValid && c_q.txCount == 10'h000 && !lineBlockEnd
      |-> txLimit == 10'h200)
      else $error("zero limit not 512");
   a_etx_order: assert property (@(posedge clock) disable iff (rst)
      inValid && !inCtl && inReady && c_q.endHold && !c_q.contHold && c_q.mask[1]
      |=> inValid && inCtl && inData == 8'h02)
      else $error("end marker missing after block");
   a_etb_order: assert property (@(posedge clock) disable iff (rst)
      inValid && !inCtl && inReady && c_q.endHold && c_q.contHold && c_q.mask[2]
      |=> inValid && inCtl && inData == 8'h03)
      else $error("continue marker missing after block");
   a_start_order: assert property (@(posedge clock) disable iff (rst)
      inValid && inCtl && inData == 8'h01 && inReady
      |=> inValid && !inCtl && inData == c_q.byteHold)
      else $error("data byte not after start marker");
   a_hold_stall: assert property (@(posedge clock) disable iff (rst)
      inValid && !inReady |=> inValid && $stable(inData) && $stable(inCtl))
      else $error("inbound word changed while stalled");
   a_parity_none: assert property (@(posedge clock) disable iff (rst)
      c_q.parity == 8'h00 && txTake |=> !lineParity)
      else $error("parity bit set with parity off");
   a_ext_clock: assert property (@(posedge clock) disable iff (rst)
      (c_q.speed == 8'h00) [*3] |-> !baudTick && extClockSel)
      else $error("internal tick with external clock");
   a_handshake: assert property (@(posedge clock) disable iff (rst)
      (c_q.handshake == 8'h00) [*2] |-> !hwHandshakeEn)
      else $error("handshake on with register zero");
endmodule

//--- tb/dlp_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Remote host on the serial link
// ****************************************************************
module dlp_host_model (
   input wire logic linkClock,
   input wire logic rxReady,
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxEnd,
   output logic rxCont,
   output logic lineReady,
   output logic carrier
);
   // Host paces all traffic, so the line starts ready; setLine can drop it
   initial begin
      rxValid = 1'b0;
      rxData = 8'h00;
      rxEnd = 1'b0;
      rxCont = 1'b0;
      lineReady = 1'b1;
      carrier = 1'b1;
   end

   // Offer one byte, hold it until taken, then scramble the released bus
   task automatic sendByte(input logic [7:0] d, input logic e, input logic c);
      @(posedge linkClock);
      rxValid <= 1'b1;
      rxData <= d;
      rxEnd <= e;
      rxCont <= c;
      do @(posedge linkClock); while (rxReady !== 1'b1);
      rxValid <= 1'b0;
      rxData <= ~d; // Released data must not look valid
      rxEnd <= ~e;
      rxCont <= ~c;
   endtask

   // Drop or restore carrier and line ready on a link edge
   task automatic setLine(input logic car, input logic rdy);
      @(posedge linkClock);
      carrier <= car;
      lineReady <= rdy;
   endtask
endmodule

//--- tb/dlp_port_tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Register, inbound and transmit checks
// ****************************************************************
module dlp_port_tb_top;
   logic clock = 1'b0, linkClock = 1'b0, rst = 1'b1;
   logic regWrite = 1'b0, regRead = 1'b0, inReady = 1'b0;
   logic txValid = 1'b0, txLast = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, txData = 8'h00;
   logic [7:0] regRdData, rxData, inData, lineData, groupChar, unitChar;
   logic rxValid, rxEnd, rxCont, rxReady, inValid, inCtl, txReady, lineReady;
   logic lineValid, lineParity, lineBlockEnd, txAbort, carrier, lostCarrier;
   logic baudTick, extClockSel, hwHandshakeEn;
   int badCount = 0, testsRun = 0;

   // Core at 50 MHz, link at an unrelated 6 ns period
   always #10 clock = ~clock;
   always #3 linkClock = ~linkClock;

   dlp_port #(.LOST_UNIT_CYC(10), .TX_UNIT_CYC(20)) dut_u (.clock(clock), .rst(rst),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .linkClock(linkClock), .rxValid(rxValid), .rxData(rxData),
      .rxEnd(rxEnd), .rxCont(rxCont), .rxReady(rxReady), .inValid(inValid),
      .inData(inData), .inCtl(inCtl), .inReady(inReady), .txValid(txValid),
      .txData(txData), .txLast(txLast), .txReady(txReady), .lineReady(lineReady),
      .lineValid(lineValid), .lineData(lineData), .lineParity(lineParity),
      .lineBlockEnd(lineBlockEnd), .txAbort(txAbort), .carrier(carrier),
      .lostCarrier(lostCarrier), .baudTick(baudTick), .extClockSel(extClockSel),
      .hwHandshakeEn(hwHandshakeEn), .groupChar(groupChar), .unitChar(unitChar));

   dlp_host_model host_u (.linkClock(linkClock), .rxReady(rxReady), .rxValid(rxValid),
      .rxData(rxData), .rxEnd(rxEnd), .rxCont(rxCont), .lineReady(lineReady),
      .carrier(carrier));

   task automatic testDone();
      if (badCount == 0 && testsRun > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
      testsRun++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic regWr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   // Data is registered, so it is looked at just after the taking edge
   task automatic regChk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk({1'b0, regRdData}, {1'b0, exp}, "register read");
   endtask

   // Take one inbound word; the bound guards against a stuck queue
   task automatic popIn(input logic ctl, input logic [7:0] exp);
      int n;
      for (n = 0; n < 40 && inValid !== 1'b1; n++) @(posedge clock) #1;
      chk({8'h00, inValid}, 9'h001, "inbound valid");
      chk({inCtl, inData}, {ctl, exp}, "inbound word");
      @(posedge clock) inReady <= 1'b1;
      @(posedge clock) inReady <= 1'b0;
      #1;
   endtask

   // One byte out; txReady seen high now means taken at the next edge
   task automatic txByte(input logic [7:0] d, input logic par, input logic fin);
      int n;
      @(posedge clock);
      txValid <= 1'b1;
      txData <= d;
      #1;
      for (n = 0; n < 40 && txReady !== 1'b1; n++) @(posedge clock) #1;
      @(posedge clock) txValid <= 1'b0;
      #1 chk({lineValid, lineData}, {1'b1, d}, "tx data");
      chk({7'h00, lineBlockEnd, lineParity}, {7'h00, fin, par}, "tx end");
   endtask

   initial begin
      int n;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      regChk(dlp_pkg::REG_CTRL_BLOCK_MASK, 8'h06);
      regChk(dlp_pkg::REG_GROUP_CODE, 8'h01);
      regChk(dlp_pkg::REG_TX_BLOCK_LIMIT, 8'h00);
      regChk(dlp_pkg::REG_PARITY, 8'h00);
      chk({1'b0, groupChar}, 9'h041, "group char");
      regWr(dlp_pkg::REG_GROUP_CODE, 8'h03);
      regWr(dlp_pkg::REG_UNIT_CODE, 8'h00);
      regWr(dlp_pkg::REG_GROUP_CODE, 8'h1b);
      @(posedge clock) #1;
      chk({groupChar, 1'b0}, 9'h086, "group char");
      chk({1'b0, unitChar}, 9'h040, "unit char");
      regWr(8'h19, 8'h5a);
      regChk(8'h19, 8'h00);
      regWr(dlp_pkg::REG_PARITY, 8'h01);
      regWr(dlp_pkg::REG_PARITY, 8'h02);
      regChk(dlp_pkg::REG_PARITY, 8'h01);
      regWr(dlp_pkg::REG_LINE_SPEED, 8'h00);
      regWr(dlp_pkg::REG_HANDSHAKE, 8'h01);
      @(posedge clock) #1;
      chk({7'h00, extClockSel, hwHandshakeEn}, 9'h003, "speed and handshake");
      // Default mask: data then end-of-text marker, no start marker
      host_u.sendByte(8'h55, 1'b1, 1'b0);
      popIn(1'b0, 8'h55);
      popIn(1'b1, dlp_pkg::CB_BLOCK_ETX);
      regWr(dlp_pkg::REG_CTRL_BLOCK_MASK, 8'h07);
      host_u.sendByte(8'ha3, 1'b1, 1'b1);
      popIn(1'b1, dlp_pkg::CB_BLOCK_START);
      popIn(1'b0, 8'ha3);
      popIn(1'b1, dlp_pkg::CB_BLOCK_ETB);
      // Start marker only on the byte after a block end
      host_u.sendByte(8'h11, 1'b0, 1'b0);
      popIn(1'b1, dlp_pkg::CB_BLOCK_START);
      popIn(1'b0, 8'h11);
      host_u.sendByte(8'h22, 1'b1, 1'b0);
      popIn(1'b0, 8'h22);
      popIn(1'b1, dlp_pkg::CB_BLOCK_ETX);
      // Limit of one word pair closes the block on the second byte
      regWr(dlp_pkg::REG_TX_BLOCK_LIMIT, 8'h01);
      txByte(8'h01, 1'b0, 1'b0);
      txByte(8'h03, 1'b1, 1'b1);
      txByte(8'h07, 1'b0, 1'b0);
      // Carrier gone for 40 units of 10 cycles in this bench
      host_u.setLine(1'b0, 1'b1);
      repeat (390) @(posedge clock);
      #1 chk({8'h00, lostCarrier}, 9'h000, "carrier early");
      repeat (20) @(posedge clock);
      #1 chk({8'h00, lostCarrier}, 9'h001, "carrier lost");
      // Stall of 10 units of 20 cycles ends in an abort pulse
      host_u.setLine(1'b1, 1'b0);
      repeat (5) @(posedge clock);
      txValid <= 1'b1;
      for (n = 0; n < 260 && txAbort !== 1'b1; n++) @(posedge clock) #1;
      chk({8'h00, n > 195 && n < 205}, 9'h001, "stall abort");
      @(posedge clock) txValid <= 1'b0;
      host_u.setLine(1'b1, 1'b1);
      // Bit time at 19200 baud from the core clock
      regWr(dlp_pkg::REG_LINE_SPEED, 8'h0f);
      for (n = 0; n < 3000 && baudTick !== 1'b1; n++) @(posedge clock) #1;
      for (n = 1; n < 3000; n++) begin
         @(posedge clock) #1;
         if (baudTick === 1'b1) break;
      end
      chk({8'h00, n == dlp_pkg::CLOCK_HZ / 19200}, 9'h001, "bit time");
      testDone();
   end

   // Whole sequence needs under ten thousand core cycles
   initial begin
      repeat (20000) @(posedge clock);
      badCount++;
      testDone();
   end
endmodule
